// ==== core/ccb_top.v ====
// Byte-wide register port for the 16-bit counter and its five capture/compare channels
// Functional notes
// - Counter bits 15..8 are visible at high-byte address 0xfa.
// - High-byte read returns a snapshot refreshed only by low-byte reads.
// - Counter high-byte writes are ignored while watchdog_enable is 1.
// - Five capture low bytes at 0xfb, 0xe9, 0xeb, 0xed, 0xfd.
// - Five capture high bytes at 0xfc, 0xea, 0xec, 0xee, 0xfe.
// - Capture addresses also reach the PWM auto-reload value bytes.
// - reload_select picks capture value or auto-reload value for accesses.
// - Writing a capture low byte clears that channel's comparator_enable.
// - Writing a capture high byte sets that channel's comparator_enable.
// - Counter bits 7..0 are visible at low-byte address 0xf9.
// - Comparator function active only while comparator_enable is 1.
// - Counter low-byte writes are blocked while watchdog_enable is 1.
`include "ccb_map.vh"
module ccb_top #(
   parameter NMOD = `CCB_MODULES
) (
   input wire CLK,
   input wire RESETN,
   input wire [7:0] SFR_ADDR,
   input wire SFR_WR,
   input wire SFR_RD,
   input wire [7:0] SFR_WDATA,
   output reg [7:0] SFR_RDATA,
   output reg SFR_HIT,
   input wire WATCHDOG_ENABLE,
   input wire RELOAD_SELECT,
   input wire COUNT_EN,
   input wire [NMOD-1:0] CAP_LOAD,
   output reg [15:0] COUNTER,
   output reg [NMOD*16-1:0] CAPTURE_VALUE,
   output reg [NMOD*16-1:0] RELOAD_VALUE,
   output reg [NMOD-1:0] COMPARE_ACTIVE
);
   // Channel index returned for any address that is not a capture byte
   localparam [3:0] NO_CHAN = 4'hf;

   // Limitation: only the register face lives here; match, PWM and capture
   // engines sit outside and see the values through the output ports
   // =============================================
   // Address decode
   // =============================================
   function [3:0] cap_index;
      input [7:0] a;
      begin
         case (a)
            `CCB_ADDR_CAPL0, `CCB_ADDR_CAPH0: cap_index = 4'h0;
            `CCB_ADDR_CAPL1, `CCB_ADDR_CAPH1: cap_index = 4'h1;
            `CCB_ADDR_CAPL2, `CCB_ADDR_CAPH2: cap_index = 4'h2;
            `CCB_ADDR_CAPL3, `CCB_ADDR_CAPH3: cap_index = 4'h3;
            `CCB_ADDR_CAPL4, `CCB_ADDR_CAPH4: cap_index = 4'h4;
            default: cap_index = NO_CHAN;
         endcase
      end
   endfunction

   function is_cap_high;
      input [7:0] a;
      begin
         case (a)
            `CCB_ADDR_CAPH0, `CCB_ADDR_CAPH1, `CCB_ADDR_CAPH2: is_cap_high = 1'b1;
            `CCB_ADDR_CAPH3, `CCB_ADDR_CAPH4: is_cap_high = 1'b1;
            default: is_cap_high = 1'b0;
         endcase
      end
   endfunction

   wire [3:0] sel = cap_index(SFR_ADDR);
   wire sel_high = is_cap_high(SFR_ADDR);
   wire hit_low = (SFR_ADDR == `CCB_ADDR_CNT_LOW);
   wire hit_high = (SFR_ADDR == `CCB_ADDR_CNT_HIGH);

   reg [15:0] count_q;
   reg [7:0] snap_q;

   // =============================================
   // Capture/compare channels
   // =============================================
   wire [NMOD*16-1:0] cap_w;
   wire [NMOD*16-1:0] rel_w;
   wire [NMOD-1:0] en_w;
   wire [NMOD*8-1:0] lo_w;
   wire [NMOD*8-1:0] hi_w;

   genvar g;
   generate
      for (g = 0; g < NMOD; g = g + 1) begin : chan
         wire mine = (sel == g);
         ccb_channel u_ch (
            .CLK(CLK),
            .RESETN(RESETN),
            .wr_low(SFR_WR && mine && !sel_high),
            .wr_high(SFR_WR && mine && sel_high),
            .reload_select(RELOAD_SELECT),
            .wdata(SFR_WDATA),
            .cap_load(CAP_LOAD[g]),
            .cap_value_in(count_q),
            .capture_value(cap_w[g*16 +: 16]),
            .reload_value(rel_w[g*16 +: 16]),
            .comparator_enable(en_w[g]),
            .low_byte(lo_w[g*8 +: 8]),
            .high_byte(hi_w[g*8 +: 8])
         );
      end
   endgenerate

   // =============================================
   // Counter, snapshot and read data
   // =============================================
   // Replaces one byte of a 16-bit word; used by both counter byte writes
   function [15:0] put_byte;
      input [15:0] word;
      input [7:0] b;
      input upper;
      begin
         if (upper)
            put_byte = {b, word[7:0]};
         else
            put_byte = {word[15:8], b};
      end
   endfunction

   wire any_access = SFR_RD || SFR_WR;
   // Unmapped addresses read as zero and leave SFR_HIT low
   wire mapped = hit_low || hit_high || (sel != NO_CHAN);
   wire cnt_wr_ok = SFR_WR && !WATCHDOG_ENABLE;
   wire snap_load = SFR_RD && hit_low;

   reg [15:0] count_d;
   reg [7:0] rdata_d;
   integer i;

   // Increment first, then a software write overrides only its own byte
   always @* begin
      count_d = count_q;
      if (COUNT_EN)
         count_d = count_q + 16'h0001;
      if (cnt_wr_ok && hit_low)
         count_d = put_byte(count_d, SFR_WDATA, 1'b0);
      if (cnt_wr_ok && hit_high)
         count_d = put_byte(count_d, SFR_WDATA, 1'b1);
   end

   always @* begin
      rdata_d = `CCB_RST_BYTE;
      if (hit_low)
         rdata_d = count_q[7:0];
      else if (hit_high)
         rdata_d = snap_q;
      for (i = 0; i < NMOD; i = i + 1) begin
         if (sel == i) begin
            rdata_d = sel_high ? hi_w[i*8 +: 8] : lo_w[i*8 +: 8];
         end
      end
   end

   // Read data uses the live counter; the COUNTER port lags it by one cycle
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         count_q <= `CCB_RST_WORD;
         snap_q <= `CCB_RST_BYTE;
      end else begin
         count_q <= count_d;
         if (snap_load)
            snap_q <= count_q[15:8];
      end
   end

   // =============================================
   // Registered outputs
   // =============================================
   // Every port is a flip-flop copy so outside engines see glitch-free values
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         SFR_RDATA <= `CCB_RST_BYTE;
         SFR_HIT <= 1'b0;
         COUNTER <= `CCB_RST_WORD;
         CAPTURE_VALUE <= {NMOD*16{1'b0}};
         RELOAD_VALUE <= {NMOD*16{1'b0}};
         COMPARE_ACTIVE <= {NMOD{1'b0}};
      end else begin
         SFR_RDATA <= SFR_RD ? rdata_d : `CCB_RST_BYTE;
         SFR_HIT <= any_access && mapped;
         COUNTER <= count_q;
         CAPTURE_VALUE <= cap_w;
         RELOAD_VALUE <= rel_w;
         COMPARE_ACTIVE <= en_w;
      end
   end
endmodule

// ==== include/ccb_map.vh ====
// Register addresses, reset values and channel count of the counter/capture byte port
`ifndef CCB_MAP_VH
`define CCB_MAP_VH
`define CCB_ADDR_CNT_LOW 8'hf9
`define CCB_ADDR_CNT_HIGH 8'hfa
`define CCB_ADDR_CAPL0 8'hfb
`define CCB_ADDR_CAPH0 8'hfc
`define CCB_ADDR_CAPL1 8'he9
`define CCB_ADDR_CAPH1 8'hea
`define CCB_ADDR_CAPL2 8'heb
`define CCB_ADDR_CAPH2 8'hec
`define CCB_ADDR_CAPL3 8'hed
`define CCB_ADDR_CAPH3 8'hee
`define CCB_ADDR_CAPL4 8'hfd
`define CCB_ADDR_CAPH4 8'hfe
`define CCB_RST_BYTE 8'h00
`define CCB_RST_WORD 16'h0000
`define CCB_MODULES 5
`endif

// ==== core/ccb_channel.v ====
// One capture/compare channel: value, auto-reload value and comparator enable
`include "ccb_map.vh"
module ccb_channel (
   input wire CLK,
   input wire RESETN,
   input wire wr_low,
   input wire wr_high,
   input wire reload_select,
   input wire [7:0] wdata,
   input wire cap_load,
   input wire [15:0] cap_value_in,
   output reg [15:0] capture_value,
   output reg [15:0] reload_value,
   output reg comparator_enable,
   output wire [7:0] low_byte,
   output wire [7:0] high_byte
);
   // Byte view follows reload_select so reads see the same target as writes
   assign low_byte = reload_select ? reload_value[7:0] : capture_value[7:0];
   assign high_byte = reload_select ? reload_value[15:8] : capture_value[15:8];

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         capture_value <= `CCB_RST_WORD;
         reload_value <= `CCB_RST_WORD;
         comparator_enable <= 1'b0;
      end else begin
         if (reload_select) begin
            if (wr_low)
               reload_value[7:0] <= wdata;
            if (wr_high)
               reload_value[15:8] <= wdata;
         end else begin
            // Software write outranks a capture landing in the same cycle
            if (cap_load)
               capture_value <= cap_value_in;
            if (wr_low)
               capture_value[7:0] <= wdata;
            if (wr_high)
               capture_value[15:8] <= wdata;
         end
         if (reload_select && cap_load)
            capture_value <= cap_value_in;
         if (wr_low)
            comparator_enable <= 1'b0;
         if (wr_high)
            comparator_enable <= 1'b1;
      end
   end
endmodule

// ==== tb/ccb_sva.sv ====
// Checker for the counter/capture byte port
module ccb_sva #(parameter NMOD = 5) (
   input wire CLK,
   input wire RESETN,
   input wire [7:0] SFR_ADDR,
   input wire SFR_WR,
   input wire SFR_RD,
   input wire [7:0] SFR_WDATA,
   input wire [7:0] SFR_RDATA,
   input wire SFR_HIT,
   input wire WATCHDOG_ENABLE,
   input wire RELOAD_SELECT,
   input wire COUNT_EN,
   input wire [15:0] COUNTER,
   input wire [NMOD*16-1:0] RELOAD_VALUE,
   input wire [NMOD-1:0] COMPARE_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   // ======================================
   // Properties
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   wire rd_lo = SFR_RD && SFR_ADDR == 8'hf9;
   wire cnt_wr = SFR_WR && (SFR_ADDR == 8'hf9 || SFR_ADDR == 8'hfa);
   wire [7:0] cnt_hi = COUNTER[15:8];
   a_low_read: assert property (rd_lo |=> SFR_RDATA == COUNTER[7:0])
      else $error("low byte read differs");
   a_snap_read: assert property (rd_lo ##1 (SFR_RD && SFR_ADDR == 8'hfa)
      |=> SFR_RDATA == $past(cnt_hi)) else $error("snapshot read differs");
   a_unmapped_quiet: assert property ((SFR_RD || SFR_WR) && SFR_ADDR == 8'h00
      |=> !SFR_HIT && SFR_RDATA == 8'h00) else $error("unmapped access answered");
   a_mapped_hit: assert property (SFR_RD && SFR_ADDR == 8'hed |=> SFR_HIT)
      else $error("mapped read not hit");
   a_low_clears: assert property (SFR_WR && SFR_ADDR == 8'heb |=> ##1 !COMPARE_ACTIVE[2])
      else $error("low write kept comparator");
   a_high_sets: assert property (SFR_WR && SFR_ADDR == 8'hea |=> ##1 COMPARE_ACTIVE[1])
      else $error("high write left comparator off");
   a_wd_lock: assert property (cnt_wr && WATCHDOG_ENABLE && !COUNT_EN ##1 !COUNT_EN
      |=> $stable(COUNTER)) else $error("locked counter changed");
   a_cnt_write: assert property (cnt_wr && !WATCHDOG_ENABLE && SFR_ADDR[0] ##1 !COUNT_EN
      |=> COUNTER[7:0] == $past(SFR_WDATA, 2)) else $error("counter low write lost");
   a_reload_route: assert property (SFR_WR && RELOAD_SELECT && SFR_ADDR == 8'hfb
      |=> ##1 RELOAD_VALUE[7:0] == $past(SFR_WDATA, 2)) else $error("reload byte lost");
endmodule
bind ccb_top ccb_sva #(.NMOD(NMOD)) ccb_sva_i (.*);

// ==== tb/ccb_core_model.sv ====
// Core-side model issuing byte accesses on the register port
module ccb_core_model (
   input wire logic CLK,
   input wire logic [7:0] rdata,
   output logic [7:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   // Call at a falling edge; strobe stays up so calls may run back to back
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      wr = w;
      rd = !w;
      addr = a;
      wdata = d;
      @(negedge CLK);
      q = rdata;
   endtask
   // Released data is inverted so a stale byte never passes for a fresh one
   task idle;
      wr = 1'b0;
      rd = 1'b0;
      wdata = ~wdata;
      @(negedge CLK);
   endtask
endmodule

// ==== tb/ccb_top_tb.sv ====
// Self-checking bench for the counter/capture byte port
module ccb_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wde = 1'b0;
   logic rsel = 1'b0;
   logic cen = 1'b0;
   logic [4:0] cap_load = 5'h00;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, hit;
   wire [15:0] cnt;
   wire [79:0] capv, relv;
   wire [4:0] act;
   logic [7:0] q;
   logic [7:0] map [12] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'he9, 8'hea, 8'heb, 8'hec,
      8'hed, 8'hee, 8'hfd, 8'hfe};
   int bad_count = 0;
   int num_checks = 0;
   ccb_top ccb_top_i (.CLK(clk), .RESETN(resetn), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
      .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_HIT(hit), .WATCHDOG_ENABLE(wde),
      .RELOAD_SELECT(rsel), .COUNT_EN(cen), .CAP_LOAD(cap_load), .COUNTER(cnt),
      .CAPTURE_VALUE(capv), .RELOAD_VALUE(relv), .COMPARE_ACTIVE(act));
   ccb_core_model ccb_core_model_i (.CLK(clk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wdata));
   initial begin
      forever #20 clk = ~clk;
   end
   // ======================================
   // Helpers
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wr_b(input logic [7:0] a, input logic [7:0] d);
      ccb_core_model_i.acc(1'b1, a, d, q);
   endtask
   task rd_c(input logic [7:0] a, input logic [7:0] e);
      ccb_core_model_i.acc(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   initial begin
      #200us;
      bad_count++;
      tally_and_finish;
   end
   // ======================================
   // Sequence
   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      foreach (map[i]) begin
         rd_c(map[i], 8'h00);
         chk(hit, 1'b1);
      end
      rd_c(8'h00, 8'h00);
      chk(hit, 1'b0);
      for (int n = 0; n < 5; n++) begin
         wr_b(map[2*n+2], 8'h10 + n[7:0]);
         wr_b(map[2*n+3], 8'h20 + n[7:0]);
      end
      wr_b(8'heb, 8'h77);
      ccb_core_model_i.idle;
      for (int n = 0; n < 5; n++)
         chk(capv[16*n +: 16], {8'h20 + n[7:0], n == 2 ? 8'h77 : 8'h10 + n[7:0]});
      chk(act, 5'h1b);
      rd_c(8'heb, 8'h77);
      rsel = 1'b1;
      wr_b(8'hfb, 8'h5a);
      wr_b(8'hfc, 8'ha5);
      rd_c(8'hfb, 8'h5a);
      ccb_core_model_i.idle;
      chk(relv[15:0], 16'ha55a);
      chk(capv[15:0], 16'h2010);
      rsel = 1'b0;
      rd_c(8'hfc, 8'h20);
      wr_b(8'hf9, 8'h34);
      wr_b(8'hfa, 8'h12);
      wde = 1'b1;
      wr_b(8'hf9, 8'hff);
      wr_b(8'hfa, 8'hff);
      ccb_core_model_i.idle;
      chk(cnt, 16'h1234);
      wde = 1'b0;
      rd_c(8'hf9, 8'h34);
      wr_b(8'hfa, 8'h56);
      rd_c(8'hfa, 8'h12);
      wr_b(8'hf9, 8'hff);
      cen = 1'b1;
      rd_c(8'hf9, 8'hff);
      rd_c(8'hfa, 8'h56);
      cen = 1'b0;
      ccb_core_model_i.idle;
      chk(cnt, 16'h5701);
      cap_load = 5'h08;
      ccb_core_model_i.idle;
      cap_load = 5'h00;
      ccb_core_model_i.idle;
      chk(capv[63:48], 16'h5701);
      rd_c(8'hee, 8'h57);
      tally_and_finish;
   end
endmodule
